// *** src/pin_bank_pkg.sv ***
// constants and types shared by the local pin configuration bank
// What this block does
// - both bits clear: back channel 5 Mbps
// - rate select only: back channel 10 Mbps
// - high-speed bit set: 20 Mbps, select ignored
// - four register-only pins, output or input
// - register-pin mode overrides shared audio input
// - local and remote register access both work
// - register-only pins never taken from link
// - pin nine codes 1/9/3, level in 0x6F[1]
// - pin eight upper nibble, level in 0x6F[0]
// - pins five to seven, levels at 0x6E[7:5]
// - link pins local codes, levels 0x6E[3:0]
// - high-speed bit 4, rate select bit 6
package pin_bank_pkg;

    // =========================================================
    // register offsets
    localparam logic [7:0] OFS_PIN_NINE_CFG = 8'h1A;
    localparam logic [7:0] OFS_LINK_PIN_ZERO_CFG = 8'h1D;
    localparam logic [7:0] OFS_LINK_PINS_ONE_TWO_CFG = 8'h1E;
    localparam logic [7:0] OFS_LINK_PIN_THREE_CFG = 8'h1F;
    localparam logic [7:0] OFS_REG_PINS_FIVE_SIX_CFG = 8'h20;
    localparam logic [7:0] OFS_REG_PINS_SEVEN_EIGHT_CFG = 8'h21;
    localparam logic [7:0] OFS_BACK_CHANNEL_CTRL = 8'h23;
    localparam logic [7:0] OFS_PIN_LEVEL_STATUS_LOW = 8'h6E;
    localparam logic [7:0] OFS_PIN_LEVEL_STATUS_HIGH = 8'h6F;

    // =========================================================
    // reset values
    localparam logic [7:0] RST_PIN_CFG = 8'h00;
    localparam logic [7:0] RST_BACK_CHANNEL_CTRL = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // =========================================================
    // configuration codes of one pin nibble
    localparam logic [3:0] CODE_DRIVE_LOW = 4'h1;
    localparam logic [3:0] CODE_DRIVE_HIGH = 4'h9;
    localparam logic [3:0] CODE_INPUT = 4'h3;

    // =========================================================
    // field positions
    localparam int BIT_BC_HIGH_SPEED = 4;
    localparam int BIT_BC_RATE_SELECT = 6;
    localparam int STAT_LOW_LINK_LSB = 0;
    localparam int STAT_LOW_UNUSED = 4;
    localparam int STAT_LOW_REG_LSB = 5;
    localparam int STAT_HIGH_PIN_EIGHT = 0;
    localparam int STAT_HIGH_PIN_NINE = 1;

    // =========================================================
    // pin indices inside the bank vectors
    localparam int NUM_PINS = 9;
    localparam int NUM_LINK_PINS = 4;
    localparam int NUM_REG_PINS = 4;
    localparam int PIN_LINK_ZERO = 0;
    localparam int PIN_LINK_ONE = 1;
    localparam int PIN_LINK_TWO = 2;
    localparam int PIN_LINK_THREE = 3;
    localparam int PIN_REG_FIVE = 4;
    localparam int PIN_REG_SIX = 5;
    localparam int PIN_REG_SEVEN = 6;
    localparam int PIN_REG_EIGHT = 7;
    localparam int PIN_NINE = 8;

    // =========================================================
    // back channel timing
    localparam int CLK_HZ = 20000000;
    localparam int BC_RATE_LOW_BPS = 5000000;
    localparam int BC_RATE_MID_BPS = 10000000;
    localparam int BC_RATE_HIGH_BPS = 20000000;
    localparam int BC_DIV_W = 3;
    localparam logic [BC_DIV_W-1:0] BC_DIV_LOW = BC_DIV_W'(CLK_HZ / BC_RATE_LOW_BPS);
    localparam logic [BC_DIV_W-1:0] BC_DIV_MID = BC_DIV_W'(CLK_HZ / BC_RATE_MID_BPS);
    localparam logic [BC_DIV_W-1:0] BC_DIV_HIGH = BC_DIV_W'(CLK_HZ / BC_RATE_HIGH_BPS);
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

    typedef enum logic [1:0] {
        BC_RATE_LOW = 2'b00,
        BC_RATE_MID = 2'b01,
        BC_RATE_HIGH = 2'b11
    } bc_rate_t;

endpackage

// *** src/level_sync.sv ***
// two-flop synchronizer for pad levels entering the clock domain
`timescale 1ns/100ps
`default_nettype none
module level_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;

    // first stage feeds only the second stage
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage_one <= '0;
            sync_out <= '0;
        end else begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end

endmodule
`default_nettype wire

// *** src/pin_cfg_decode.sv ***
// decode of one four-bit pin configuration nibble
`timescale 1ns/100ps
`default_nettype none
module pin_cfg_decode
    import pin_bank_pkg::*;
(
    // configuration
    input wire logic [3:0] code,
    // decoded mode
    output logic drive_en,
    output logic drive_level,
    output logic input_en
);

    // any other code keeps the driver off
    assign drive_en = (code == CODE_DRIVE_LOW) || (code == CODE_DRIVE_HIGH);
    assign drive_level = (code == CODE_DRIVE_HIGH);
    assign input_en = (code == CODE_INPUT);

endmodule
`default_nettype wire

// *** src/local_pin_config_bank.sv ***
// register-controlled local pin bank with back channel rate decode
`timescale 1ns/100ps
`default_nettype none
module local_pin_config_bank
    import pin_bank_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // local register access
    input wire logic loc_req,
    input wire logic loc_write,
    input wire logic [7:0] loc_addr,
    input wire logic [7:0] loc_wdata,
    output logic loc_ack,
    output logic [7:0] loc_rdata,
    // remote register access from the control channel
    input wire logic rem_req,
    input wire logic rem_write,
    input wire logic [7:0] rem_addr,
    input wire logic [7:0] rem_wdata,
    output logic rem_ack,
    output logic [7:0] rem_rdata,
    // pads
    input wire logic [NUM_PINS-1:0] pad_in,
    output logic [NUM_PINS-1:0] pad_out,
    output logic [NUM_PINS-1:0] pad_oe,
    // shared audio inputs on register-only pins
    output logic [NUM_REG_PINS-1:0] audio_in_enable,
    // back channel
    input wire logic hs_strap,
    output bc_rate_t bc_rate,
    output logic [BC_DIV_W-1:0] bc_divider,
    output logic bc_bit_tick
);

    // =========================================================
    // state
    logic [7:0] cfg_pin_nine;
    logic [7:0] cfg_link_zero;
    logic [7:0] cfg_link_one_two;
    logic [7:0] cfg_link_three;
    logic [7:0] cfg_reg_five_six;
    logic [7:0] cfg_reg_seven_eight;
    logic [7:0] bc_ctrl;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic [BC_DIV_W-1:0] tick_cnt;

    logic [7:0] next_cfg_pin_nine;
    logic [7:0] next_cfg_link_zero;
    logic [7:0] next_cfg_link_one_two;
    logic [7:0] next_cfg_link_three;
    logic [7:0] next_cfg_reg_five_six;
    logic [7:0] next_cfg_reg_seven_eight;
    logic [7:0] next_bc_ctrl;
    logic [1:0] next_strap_cnt;
    logic next_strap_done;
    logic [BC_DIV_W-1:0] next_tick_cnt;
    logic next_loc_ack;
    logic [7:0] next_loc_rdata;
    logic next_rem_ack;
    logic [7:0] next_rem_rdata;
    logic [NUM_PINS-1:0] next_pad_out;
    logic [NUM_PINS-1:0] next_pad_oe;
    logic [NUM_REG_PINS-1:0] next_audio_in_enable;
    bc_rate_t next_bc_rate;
    logic [BC_DIV_W-1:0] next_bc_divider;
    logic next_bc_bit_tick;

    // =========================================================
    // pad synchronizers
    logic [NUM_PINS-1:0] pad_level;
    logic strap_level;

    level_sync #(.WIDTH(NUM_PINS)) u_pad_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(pad_in),
        .sync_out(pad_level)
    );

    level_sync #(.WIDTH(1)) u_strap_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(hs_strap),
        .sync_out(strap_level)
    );

    // =========================================================
    // per-pin decode
    logic [3:0] pin_code [NUM_PINS];
    logic [NUM_PINS-1:0] drive_en;
    logic [NUM_PINS-1:0] drive_level;
    logic [NUM_PINS-1:0] input_en;
    logic [NUM_PINS-1:0] read_level;

    // register-only pins see only their local nibbles, never link data
    assign pin_code[PIN_LINK_ZERO] = cfg_link_zero[3:0];
    assign pin_code[PIN_LINK_ONE] = cfg_link_one_two[3:0];
    assign pin_code[PIN_LINK_TWO] = cfg_link_one_two[7:4];
    assign pin_code[PIN_LINK_THREE] = cfg_link_three[3:0];
    assign pin_code[PIN_REG_FIVE] = cfg_reg_five_six[3:0];
    assign pin_code[PIN_REG_SIX] = cfg_reg_five_six[7:4];
    assign pin_code[PIN_REG_SEVEN] = cfg_reg_seven_eight[3:0];
    assign pin_code[PIN_REG_EIGHT] = cfg_reg_seven_eight[7:4];
    assign pin_code[PIN_NINE] = cfg_pin_nine[3:0];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            pin_cfg_decode u_decode (
                .code(pin_code[gi]),
                .drive_en(drive_en[gi]),
                .drive_level(drive_level[gi]),
                .input_en(input_en[gi])
            );
            // a pin reads back its level only while configured as input
            assign read_level[gi] = pad_level[gi] & input_en[gi];
        end
    endgenerate

    // =========================================================
    // status words
    logic [7:0] status_low;
    logic [7:0] status_high;

    always_comb begin
        status_low = 8'h00;
        status_high = 8'h00;
        status_low[STAT_LOW_LINK_LSB +: NUM_LINK_PINS] =
            read_level[PIN_LINK_THREE:PIN_LINK_ZERO];
        status_low[STAT_LOW_UNUSED] = 1'b0;
        status_low[STAT_LOW_REG_LSB +: 3] = read_level[PIN_REG_SEVEN:PIN_REG_FIVE];
        status_high[STAT_HIGH_PIN_EIGHT] = read_level[PIN_REG_EIGHT];
        status_high[STAT_HIGH_PIN_NINE] = read_level[PIN_NINE];
    end

    // =========================================================
    // access arbitration
    // local wins a tie; the remote side holds its request until acked
    logic loc_take;
    logic rem_take;
    logic acc_take;
    logic acc_write;
    logic [7:0] acc_addr;
    logic [7:0] acc_wdata;
    logic [7:0] acc_rdata;

    assign loc_take = loc_req && !loc_ack;
    assign rem_take = rem_req && !rem_ack && !loc_take;
    assign acc_take = loc_take || rem_take;
    assign acc_write = loc_take ? loc_write : rem_write;
    assign acc_addr = loc_take ? loc_addr : rem_addr;
    assign acc_wdata = loc_take ? loc_wdata : rem_wdata;

    always_comb begin
        unique case (acc_addr)
            OFS_PIN_NINE_CFG: acc_rdata = cfg_pin_nine;
            OFS_LINK_PIN_ZERO_CFG: acc_rdata = cfg_link_zero;
            OFS_LINK_PINS_ONE_TWO_CFG: acc_rdata = cfg_link_one_two;
            OFS_LINK_PIN_THREE_CFG: acc_rdata = cfg_link_three;
            OFS_REG_PINS_FIVE_SIX_CFG: acc_rdata = cfg_reg_five_six;
            OFS_REG_PINS_SEVEN_EIGHT_CFG: acc_rdata = cfg_reg_seven_eight;
            OFS_BACK_CHANNEL_CTRL: acc_rdata = bc_ctrl;
            OFS_PIN_LEVEL_STATUS_LOW: acc_rdata = status_low;
            OFS_PIN_LEVEL_STATUS_HIGH: acc_rdata = status_high;
            default: acc_rdata = UNMAPPED_READ;
        endcase
    end

    // =========================================================
    // back channel rate decode
    bc_rate_t rate_sel;
    logic [BC_DIV_W-1:0] div_sel;

    always_comb begin
        if (bc_ctrl[BIT_BC_HIGH_SPEED]) begin
            rate_sel = BC_RATE_HIGH;
            div_sel = BC_DIV_HIGH;
        end else if (bc_ctrl[BIT_BC_RATE_SELECT]) begin
            rate_sel = BC_RATE_MID;
            div_sel = BC_DIV_MID;
        end else begin
            rate_sel = BC_RATE_LOW;
            div_sel = BC_DIV_LOW;
        end
    end

    // =========================================================
    // next values
    always_comb begin
        next_cfg_pin_nine = cfg_pin_nine;
        next_cfg_link_zero = cfg_link_zero;
        next_cfg_link_one_two = cfg_link_one_two;
        next_cfg_link_three = cfg_link_three;
        next_cfg_reg_five_six = cfg_reg_five_six;
        next_cfg_reg_seven_eight = cfg_reg_seven_eight;
        next_bc_ctrl = bc_ctrl;
        next_strap_cnt = strap_cnt;
        next_strap_done = strap_done;

        if (acc_take && acc_write) begin
            unique case (acc_addr)
                OFS_PIN_NINE_CFG: next_cfg_pin_nine = acc_wdata;
                OFS_LINK_PIN_ZERO_CFG: next_cfg_link_zero = acc_wdata;
                OFS_LINK_PINS_ONE_TWO_CFG: next_cfg_link_one_two = acc_wdata;
                OFS_LINK_PIN_THREE_CFG: next_cfg_link_three = acc_wdata;
                OFS_REG_PINS_FIVE_SIX_CFG: next_cfg_reg_five_six = acc_wdata;
                OFS_REG_PINS_SEVEN_EIGHT_CFG: next_cfg_reg_seven_eight = acc_wdata;
                OFS_BACK_CHANNEL_CTRL: next_bc_ctrl = acc_wdata;
                default: begin
                end
            endcase
        end

        // strap is caught once the synchronizer has settled after reset;
        // it beats a register write landing on that same edge
        if (!strap_done) begin
            if (strap_cnt == STRAP_SETTLE) begin
                next_bc_ctrl[BIT_BC_HIGH_SPEED] = strap_level;
                next_strap_done = 1'b1;
            end else begin
                next_strap_cnt = strap_cnt + 2'h1;
            end
        end

        next_loc_ack = loc_take;
        next_loc_rdata = loc_take ? acc_rdata : loc_rdata;
        next_rem_ack = rem_take;
        next_rem_rdata = rem_take ? acc_rdata : rem_rdata;

        next_pad_oe = drive_en;
        next_pad_out = drive_en & drive_level;
        // pad owned by the register pin blocks the audio serial input
        next_audio_in_enable = ~(drive_en[PIN_REG_EIGHT:PIN_REG_FIVE]
            | input_en[PIN_REG_EIGHT:PIN_REG_FIVE]);

        next_bc_rate = rate_sel;
        next_bc_divider = div_sel;
        // restart the bit timer on a rate change to avoid a short bit
        if (div_sel != bc_divider || tick_cnt >= div_sel - BC_DIV_W'(1)) begin
            next_tick_cnt = '0;
        end else begin
            next_tick_cnt = tick_cnt + BC_DIV_W'(1);
        end
        next_bc_bit_tick = (div_sel == bc_divider) && (tick_cnt == div_sel - BC_DIV_W'(1));
    end

    // =========================================================
    // registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_pin_nine <= RST_PIN_CFG;
            cfg_link_zero <= RST_PIN_CFG;
            cfg_link_one_two <= RST_PIN_CFG;
            cfg_link_three <= RST_PIN_CFG;
            cfg_reg_five_six <= RST_PIN_CFG;
            cfg_reg_seven_eight <= RST_PIN_CFG;
            bc_ctrl <= RST_BACK_CHANNEL_CTRL;
            strap_cnt <= 2'h0;
            strap_done <= 1'b0;
            tick_cnt <= '0;
            loc_ack <= 1'b0;
            loc_rdata <= 8'h00;
            rem_ack <= 1'b0;
            rem_rdata <= 8'h00;
            pad_out <= '0;
            pad_oe <= '0;
            audio_in_enable <= {NUM_REG_PINS{1'b1}};
            bc_rate <= BC_RATE_LOW;
            bc_divider <= BC_DIV_LOW;
            bc_bit_tick <= 1'b0;
        end else begin
            cfg_pin_nine <= next_cfg_pin_nine;
            cfg_link_zero <= next_cfg_link_zero;
            cfg_link_one_two <= next_cfg_link_one_two;
            cfg_link_three <= next_cfg_link_three;
            cfg_reg_five_six <= next_cfg_reg_five_six;
            cfg_reg_seven_eight <= next_cfg_reg_seven_eight;
            bc_ctrl <= next_bc_ctrl;
            strap_cnt <= next_strap_cnt;
            strap_done <= next_strap_done;
            tick_cnt <= next_tick_cnt;
            loc_ack <= next_loc_ack;
            loc_rdata <= next_loc_rdata;
            rem_ack <= next_rem_ack;
            rem_rdata <= next_rem_rdata;
            pad_out <= next_pad_out;
            pad_oe <= next_pad_oe;
            audio_in_enable <= next_audio_in_enable;
            bc_rate <= next_bc_rate;
            bc_divider <= next_bc_divider;
            bc_bit_tick <= next_bc_bit_tick;
        end
    end

endmodule
`default_nettype wire

// *** verif/pin_bank_assertions.sv ***
// assertion checker bound to the local pin configuration bank
`timescale 1ns/100ps
`default_nettype none
module pin_bank_checker
    import pin_bank_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register access
    input wire logic loc_req,
    input wire logic loc_write,
    input wire logic [7:0] loc_addr,
    input wire logic [7:0] loc_wdata,
    input wire logic loc_ack,
    input wire logic [7:0] loc_rdata,
    input wire logic rem_req,
    input wire logic rem_ack,
    // pads and back channel
    input wire logic [NUM_PINS-1:0] pad_out,
    input wire logic [NUM_PINS-1:0] pad_oe,
    input wire logic [NUM_REG_PINS-1:0] audio_in_enable,
    input wire bc_rate_t bc_rate,
    input wire logic [BC_DIV_W-1:0] bc_divider,
    input wire logic bc_bit_tick
);
    // ==========================================================
    // helpers
    logic [3:0] wd_lo;
    logic wd_hs;
    logic wd_sel;
    assign wd_lo = loc_wdata[3:0];
    assign wd_hs = loc_wdata[BIT_BC_HIGH_SPEED];
    assign wd_sel = loc_wdata[BIT_BC_RATE_SELECT];

    // {drive enable, drive level} a nibble asks for
    function automatic logic [1:0] drive_of(input logic [3:0] c);
        return {c == CODE_DRIVE_LOW || c == CODE_DRIVE_HIGH, c == CODE_DRIVE_HIGH};
    endfunction

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence loc_take;
        loc_req && !loc_ack;
    endsequence
    sequence loc_wr(a);
        loc_req && !loc_ack && loc_write && loc_addr == a;
    endsequence

    // ==========================================================
    // properties
    loc_answer_a: assert property (loc_take |=> loc_ack ##1 !loc_ack)
        else $error("local access not answered with one pulse");
    rem_answer_a: assert property ((rem_req && !rem_ack && !(loc_req && !loc_ack)) |=> rem_ack)
        else $error("remote access not answered");
    rem_yield_a: assert property ((rem_req && !rem_ack && loc_req && !loc_ack) |=> !rem_ack)
        else $error("remote answered while local taken");
    pin_nine_drive_a: assert property (loc_wr(OFS_PIN_NINE_CFG) |-> ##2
        {pad_oe[PIN_NINE], pad_out[PIN_NINE]} == drive_of($past(wd_lo, 2)))
        else $error("pin nine drive wrong after write");
    audio_override_a: assert property (loc_wr(OFS_REG_PINS_FIVE_SIX_CFG) |-> ##2
        audio_in_enable[0] == (drive_of($past(wd_lo, 2)) == 2'b00 && $past(wd_lo, 2) != CODE_INPUT))
        else $error("audio input enable wrong");
    drive_gated_a: assert property ((pad_out & ~pad_oe) == '0)
        else $error("pad level driven while disabled");
    rate_decode_a: assert property (loc_wr(OFS_BACK_CHANNEL_CTRL) |-> ##2
        bc_rate == ($past(wd_hs, 2) ? BC_RATE_HIGH : $past(wd_sel, 2) ? BC_RATE_MID : BC_RATE_LOW))
        else $error("back channel rate wrong after write");
    divider_match_a: assert property (bc_divider == (bc_rate == BC_RATE_HIGH ? BC_DIV_HIGH :
        bc_rate == BC_RATE_MID ? BC_DIV_MID : BC_DIV_LOW))
        else $error("divider does not match rate");
    tick_spacing_a: assert property ((bc_bit_tick && bc_divider == 3'h4) |=>
        (!bc_bit_tick || bc_divider != 3'h4) [*3] ##1 (bc_bit_tick || bc_divider != 3'h4))
        else $error("tick spacing wrong at divide by four");
    status_gap_a: assert property ((loc_take ##0 !loc_write && loc_addr == OFS_PIN_LEVEL_STATUS_LOW)
        |=> loc_ack && !loc_rdata[STAT_LOW_UNUSED])
        else $error("unused status bit set");
endmodule

bind local_pin_config_bank pin_bank_checker chk (
    .clk(clk), .sys_rst(sys_rst), .loc_req(loc_req), .loc_write(loc_write),
    .loc_addr(loc_addr), .loc_wdata(loc_wdata), .loc_ack(loc_ack), .loc_rdata(loc_rdata),
    .rem_req(rem_req), .rem_ack(rem_ack), .pad_out(pad_out), .pad_oe(pad_oe),
    .audio_in_enable(audio_in_enable), .bc_rate(bc_rate), .bc_divider(bc_divider),
    .bc_bit_tick(bc_bit_tick)
);
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench for the local pin configuration bank
`timescale 1ns/100ps
`default_nettype none
module tb
    import pin_bank_pkg::*;
;
    // ==========================================================
    // stimulus and observed signals
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic loc_req = 1'b0;
    logic loc_write = 1'b0;
    logic rem_req = 1'b0;
    logic rem_write = 1'b0;
    logic [7:0] loc_addr = 8'h00;
    logic [7:0] loc_wdata = 8'h00;
    logic [7:0] rem_addr = 8'h00;
    logic [7:0] rem_wdata = 8'h00;
    logic [8:0] pad_in = 9'h000;
    logic hs_strap = 1'b0;
    logic loc_ack, rem_ack, bc_bit_tick;
    logic [7:0] loc_rdata, rem_rdata;
    logic [8:0] pad_out, pad_oe;
    logic [3:0] audio_in_enable;
    logic [2:0] bc_divider;
    bc_rate_t bc_rate;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    localparam logic [7:0] PIN_ADDR [9] = '{8'h1D, 8'h1E, 8'h1E, 8'h1F, 8'h20, 8'h20, 8'h21,
        8'h21, 8'h1A};
    localparam int PIN_SHIFT [9] = '{0, 0, 4, 0, 0, 4, 0, 4, 0};

    always #25 clk = ~clk;

    // strap raised for one reset only, to see the fast rate captured
    local_pin_config_bank dut (
        .clk(clk), .sys_rst(sys_rst), .loc_req(loc_req), .loc_write(loc_write),
        .loc_addr(loc_addr), .loc_wdata(loc_wdata), .loc_ack(loc_ack), .loc_rdata(loc_rdata),
        .rem_req(rem_req), .rem_write(rem_write), .rem_addr(rem_addr), .rem_wdata(rem_wdata),
        .rem_ack(rem_ack), .rem_rdata(rem_rdata), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe(pad_oe), .audio_in_enable(audio_in_enable), .hs_strap(hs_strap),
        .bc_rate(bc_rate), .bc_divider(bc_divider), .bc_bit_tick(bc_bit_tick)
    );

    // ==========================================================
    // reporting
    task automatic wrap_up();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_pins(input string what, input logic [8:0] exp, input logic [8:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up();
        end
    end

    // ==========================================================
    // register access, request held until its acknowledge
    task automatic access(input bit rem, input bit wr, input logic [7:0] a,
        input logic [7:0] d, output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        if (rem) begin
            rem_req <= 1'b1;
            rem_write <= wr;
            rem_addr <= a;
            rem_wdata <= d;
        end else begin
            loc_req <= 1'b1;
            loc_write <= wr;
            loc_addr <= a;
            loc_wdata <= d;
        end
        do begin
            @(posedge clk);
            #1;
            n++;
        end while ((rem ? rem_ack : loc_ack) !== 1'b1 && n < 20);
        chk_byte("access ack", 8'h01, {7'h00, rem ? rem_ack : loc_ack});
        rd = rem ? rem_rdata : loc_rdata;
        // hold the request over the edge that samples the acknowledge
        @(posedge clk);
        if (rem) rem_req <= 1'b0;
        else loc_req <= 1'b0;
    endtask

    task automatic do_reset(input bit strap);
        @(posedge clk);
        sys_rst <= 1'b1;
        hs_strap <= strap;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask

    function automatic int stat_bit(input int i);
        return (i < 4) ? i : (i < 7) ? i + 1 : i - 7;
    endfunction

    // ==========================================================
    // scenarios
    task automatic test_reset();
        logic [7:0] v;
        chk_pins("pad_oe", 9'h000, pad_oe);
        chk_byte("audio_in_enable", 8'h0F, {4'h0, audio_in_enable});
        chk_byte("bc_divider", {5'h00, BC_DIV_LOW}, {5'h00, bc_divider});
        for (int i = 0; i < 9; i++) begin
            access(i[0], 0, PIN_ADDR[i], 8'h00, v);
            chk_byte("config reset", RST_PIN_CFG, v);
        end
        access(0, 1, OFS_PIN_LEVEL_STATUS_LOW, 8'hFF, v);
        access(0, 0, OFS_PIN_LEVEL_STATUS_LOW, 8'h00, v);
        chk_byte("status after write", 8'h00, v);
        access(1, 1, 8'h55, 8'hA5, v);
        access(1, 0, 8'h55, 8'h00, v);
        chk_byte("unmapped read", UNMAPPED_READ, v);
    endtask

    task automatic test_pins();
        logic [3:0] codes [5] = '{4'h1, 4'h9, 4'h3, 4'h0, 4'h5};
        logic [7:0] v, sa, cfg;
        bit drv;
        for (int i = 0; i < 9; i++) begin
            sa = (i < 7) ? OFS_PIN_LEVEL_STATUS_LOW : OFS_PIN_LEVEL_STATUS_HIGH;
            for (int k = 0; k < 5; k++) begin
                cfg = 8'(codes[k]) << PIN_SHIFT[i];
                drv = codes[k] == 4'h1 || codes[k] == 4'h9;
                access(i[0], 1, PIN_ADDR[i], cfg, v);
                @(posedge clk);
                #1;
                chk_pins("pad_oe", drv ? 9'h001 << i : 9'h000, pad_oe);
                chk_pins("pad_out", codes[k] == 4'h9 ? 9'h001 << i : 9'h000, pad_out);
                if (i >= 4 && i < 8) begin
                    chk_byte("audio_in_enable", (drv || codes[k] == 4'h3) ?
                        8'h0F & ~(8'h01 << (i - 4)) : 8'h0F, {4'h0, audio_in_enable});
                end
                @(posedge clk);
                pad_in <= 9'h1FF;
                repeat (3) @(posedge clk);
                access(0, 0, sa, 8'h00, v);
                chk_byte("status high", codes[k] == 4'h3 ? 8'h01 << stat_bit(i) : 8'h00, v);
                pad_in <= 9'h000;
                repeat (3) @(posedge clk);
                access(0, 0, sa, 8'h00, v);
                chk_byte("status low", 8'h00, v);
                access(!i[0], 0, PIN_ADDR[i], 8'h00, v);
                chk_byte("config readback", cfg, v);
            end
        end
    endtask

    task automatic test_back_channel();
        logic [7:0] ctl [4] = '{8'h00, 8'h40, 8'h10, 8'h50};
        logic [2:0] ed [4] = '{BC_DIV_LOW, BC_DIV_MID, BC_DIV_HIGH, BC_DIV_HIGH};
        logic [1:0] er [4] = '{2'b00, 2'b01, 2'b11, 2'b11};
        logic [7:0] v;
        int n;
        for (int k = 0; k < 4; k++) begin
            access(0, 1, OFS_BACK_CHANNEL_CTRL, ctl[k], v);
            access(1, 0, OFS_BACK_CHANNEL_CTRL, 8'h00, v);
            chk_byte("bc control", ctl[k], v);
            chk_byte("bc_rate", {6'h00, er[k]}, {6'h00, bc_rate});
            chk_byte("bc_divider", {5'h00, ed[k]}, {5'h00, bc_divider});
            for (int w = 0; w < 2; w++) begin
                n = 0;
                do begin
                    @(posedge clk);
                    #1;
                    n++;
                end while (bc_bit_tick !== 1'b1 && n < 20);
            end
            chk_byte("tick spacing", {5'h00, ed[k]}, 8'(n));
        end
    endtask

    task automatic test_contention();
        logic [7:0] a, b;
        fork
            access(0, 1, OFS_LINK_PIN_ZERO_CFG, 8'h01, a);
            access(1, 1, OFS_PIN_NINE_CFG, 8'h09, b);
        join
        access(1, 0, OFS_LINK_PIN_ZERO_CFG, 8'h00, a);
        access(0, 0, OFS_PIN_NINE_CFG, 8'h00, b);
        chk_byte("local write", 8'h01, a);
        chk_byte("remote write", 8'h09, b);
        @(posedge clk);
        #1;
        chk_pins("pad_oe", 9'h101, pad_oe);
        chk_pins("pad_out", 9'h100, pad_out);
    endtask

    initial begin
        do_reset(0);
        test_reset();
        test_pins();
        test_back_channel();
        test_contention();
        // a strapped reset in mid-run selects the fast back channel
        do_reset(1);
        chk_byte("strapped rate", 8'h03, {6'h00, bc_rate});
        chk_byte("strapped divider", {5'h00, BC_DIV_HIGH}, {5'h00, bc_divider});
        // a third reset, unstrapped, must bring every field that test_reset checks back
        do_reset(0);
        test_reset();
        wrap_up();
    end
endmodule
`default_nettype wire
